/* spc_consts.vh */
// Constants for the switch port command and identifier block.
// Assumes inclusion by the design files only; holds definitions and no logic.
`ifndef SPC_CONSTS_VH
`define SPC_CONSTS_VH
`define SPC_OFF_DEVID 8'h00
`define SPC_OFF_CMD 8'h04
`define SPC_DEVID_LSB 16
// Default identifier; the value is arbitrary.
`define SPC_DEVID_RST 16'hA5C3
`define SPC_CMD_RST 16'h0000
`define SPC_CMD_RW_MASK 16'h0547
`define SPC_BIT_IO 0
`define SPC_BIT_MEM 1
`define SPC_BIT_BME 2
`define SPC_BIT_PERR 6
`define SPC_BIT_SERR 8
`define SPC_BIT_INTD 10
`define SPC_BIT_MDPE 24
`define SPC_BIT_SSE 30
`define SPC_KIND_MEM 2'h0
`define SPC_KIND_IO 2'h1
`endif

/* spc_sync.v */
// Two-stage synchroniser for one level from outside the clock domain.
// Assumes the input is a quasi-static level.
`timescale 1ns/1ps
module spc_sync (
    // Clock and reset
    input wire core_clk_i,
    input wire rst_b_i,
    // Level
    input wire d_i,
    output reg q_o
);
    reg meta_q;
    always @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            meta_q <= 1'b0;
            q_o <= 1'b0;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule // spc_sync

/* spc_gate.v */
// Transaction gate: decides accept, forward or unsupported per request.
// Assumes one request pulse per cycle from same-clock logic.
`timescale 1ns/1ps
`include "spc_consts.vh"
module spc_gate (
    // Clock and reset
    input wire core_clk_i,
    input wire rst_b_i,
    // Command enables
    input wire io_en_i,
    input wire mem_en_i,
    input wire bme_i,
    // Primary side requests
    input wire pri_req_i,
    input wire [1:0] pri_kind_i,
    // Downstream side requests
    input wire dn_req_i,
    input wire [1:0] dn_kind_i,
    input wire dn_np_i,
    // Decisions
    output reg pri_accept_o,
    output reg pri_ignore_o,
    output reg up_fwd_o,
    output reg dn_ur_o,
    output reg dn_ur_cpl_o
);
    wire pri_io = pri_kind_i == `SPC_KIND_IO;
    wire pri_mem = pri_kind_i == `SPC_KIND_MEM;
    wire dn_mio = (dn_kind_i == `SPC_KIND_IO) || (dn_kind_i == `SPC_KIND_MEM);
    wire pri_ok = (pri_io && io_en_i) || (pri_mem && mem_en_i);
    always @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            pri_accept_o <= 1'b0;
            pri_ignore_o <= 1'b0;
            up_fwd_o <= 1'b0;
            dn_ur_o <= 1'b0;
            dn_ur_cpl_o <= 1'b0;
        end else begin
            pri_accept_o <= pri_req_i && pri_ok;
            pri_ignore_o <= pri_req_i && !pri_ok;
            up_fwd_o <= dn_req_i && dn_mio && bme_i;
            dn_ur_o <= dn_req_i && dn_mio && !bme_i;
            dn_ur_cpl_o <= dn_req_i && dn_mio && !bme_i && dn_np_i;
        end
    end
endmodule // spc_gate

/* spc_top.v */
// Identifier and command register bank of a switch port configuration header.
// Assumes config accesses are one-cycle strobes on the core clock.
`timescale 1ns/1ps
`include "spc_consts.vh"
module spc_top #(
    // Default identifier; the value is arbitrary.
    parameter [15:0] DEVID_RST = `SPC_DEVID_RST
) (
    // Clock and reset
    input wire core_clk_i,
    input wire rst_b_i,
    // Configuration access
    input wire cfg_wr_i,
    input wire cfg_rd_i,
    input wire [7:0] cfg_addr_i,
    input wire [31:0] cfg_wdata_i,
    input wire [3:0] cfg_be_i,
    output reg [31:0] cfg_rdata_o,
    output reg cfg_rvalid_o,
    // Identifier load from management bus or EEPROM
    input wire id_load_i,
    input wire [15:0] id_value_i,
    // Transaction requests
    input wire pri_req_i,
    input wire [1:0] pri_kind_i,
    input wire dn_req_i,
    input wire [1:0] dn_kind_i,
    input wire dn_np_i,
    // Error and interrupt events
    input wire perr_det_i,
    input wire err_msg_i,
    input wire int_own_i,
    input wire int_dn_i,
    input wire perr_pin_i,
    // Decisions and messages
    output wire pri_accept_o,
    output wire pri_ignore_o,
    output wire up_fwd_o,
    output wire dn_ur_o,
    output wire dn_ur_cpl_o,
    output reg perr_act_o,
    output reg err_report_o,
    output reg int_msg_o,
    output reg [15:0] cmd_o
);
    // Identifier, command and the two status flags that this bank owns.
    localparam [15:0] CMD_RW = `SPC_CMD_RW_MASK;
    localparam [15:0] CMD_RST = `SPC_CMD_RST;
    reg [15:0] devid_q;
    reg [15:0] devid_d;
    reg [15:0] cmd_q;
    wire [15:0] cmd_d;
    reg mdpe_q;
    reg mdpe_d;
    reg sse_q;
    reg sse_d;
    // Next values of the registered outputs.
    reg [31:0] cfg_rdata_d;
    reg cfg_rvalid_d;
    reg perr_act_d;
    reg err_report_d;
    reg int_msg_d;
    reg [15:0] cmd_copy_d;
    // Access decode and command qualifiers.
    wire perr_ext;
    wire perr_any;
    wire sel_cmd;
    wire wr_cmd;
    wire wr_sts;
    wire [15:0] wmask;
    wire serr_en;
    wire perr_en;
    wire intx_off;
    wire perr_set;
    wire perr_clr;
    wire sse_set;
    wire sse_clr;
    wire devid_empty;
    reg [31:0] id_word;
    reg [31:0] sts_cmd_word;

    assign perr_any = perr_det_i | perr_ext;
    assign sel_cmd = cfg_addr_i == `SPC_OFF_CMD;
    assign wr_cmd = cfg_wr_i && sel_cmd;
    // Status flags clear only through the top byte lane.
    assign wr_sts = wr_cmd && cfg_be_i[3];
    assign wmask = {{8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}} & CMD_RW;
    assign serr_en = cmd_q[`SPC_BIT_SERR];
    assign perr_en = cmd_q[`SPC_BIT_PERR];
    assign intx_off = cmd_q[`SPC_BIT_INTD];
    assign devid_empty = devid_q == 16'h0000;

    // Pin-sourced parity error passes two flops before use.
    spc_sync u_sync (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .d_i(perr_pin_i),
        .q_o(perr_ext)
    );

    spc_gate u_gate (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .io_en_i(cmd_q[`SPC_BIT_IO]),
        .mem_en_i(cmd_q[`SPC_BIT_MEM]),
        .bme_i(cmd_q[`SPC_BIT_BME]),
        .pri_req_i(pri_req_i),
        .pri_kind_i(pri_kind_i),
        .dn_req_i(dn_req_i),
        .dn_kind_i(dn_kind_i),
        .dn_np_i(dn_np_i),
        .pri_accept_o(pri_accept_o),
        .pri_ignore_o(pri_ignore_o),
        .up_fwd_o(up_fwd_o),
        .dn_ur_o(dn_ur_o),
        .dn_ur_cpl_o(dn_ur_cpl_o)
    );

    // Writable enables take the write; every other bit is held at zero.
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_cmd_bit
            if (CMD_RW[gi]) begin : g_rw
                assign cmd_d[gi] = (wr_cmd && wmask[gi]) ? cfg_wdata_i[gi] : cmd_q[gi];
            end else begin : g_fixed
                assign cmd_d[gi] = 1'b0;
            end
        end
    endgenerate

    always @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            cmd_q <= CMD_RST;
        end else begin
            cmd_q <= cmd_d;
        end
    end

    always @* begin
        devid_d = devid_q;
        if (id_load_i) begin
            devid_d = id_value_i;
        end else if (devid_empty) begin
            devid_d = DEVID_RST;
        end
    end

    always @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            devid_q <= 16'h0000;
        end else begin
            devid_q <= devid_d;
        end
    end

    assign perr_set = perr_any && perr_en;
    assign perr_clr = wr_sts && cfg_wdata_i[`SPC_BIT_MDPE];

    // A set in the same cycle as a clear wins, so no event is lost.
    always @* begin
        mdpe_d = mdpe_q;
        if (perr_set) begin
            mdpe_d = 1'b1;
        end else if (perr_clr) begin
            mdpe_d = 1'b0;
        end
    end

    always @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            mdpe_q <= 1'b0;
        end else begin
            mdpe_q <= mdpe_d;
        end
    end

    assign sse_set = err_msg_i && serr_en;
    assign sse_clr = wr_sts && cfg_wdata_i[`SPC_BIT_SSE];

    always @* begin
        sse_d = sse_q;
        if (sse_set) begin
            sse_d = 1'b1;
        end else if (sse_clr) begin
            sse_d = 1'b0;
        end
    end

    always @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            sse_q <= 1'b0;
        end else begin
            sse_q <= sse_d;
        end
    end

    always @* begin
        id_word = 32'h00000000;
        id_word[`SPC_DEVID_LSB +: 16] = devid_q;
    end

    always @* begin
        sts_cmd_word = 32'h00000000;
        sts_cmd_word[15:0] = cmd_q;
        sts_cmd_word[`SPC_BIT_MDPE] = mdpe_q;
        sts_cmd_word[`SPC_BIT_SSE] = sse_q;
    end

    // Read data holds until the next read strobe.
    always @* begin
        cfg_rdata_d = cfg_rdata_o;
        if (cfg_rd_i) begin
            case (cfg_addr_i)
                `SPC_OFF_DEVID: cfg_rdata_d = id_word;
                `SPC_OFF_CMD: cfg_rdata_d = sts_cmd_word;
                default: cfg_rdata_d = 32'h00000000;
            endcase
        end
    end

    always @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            cfg_rdata_o <= 32'h00000000;
        end else begin
            cfg_rdata_o <= cfg_rdata_d;
        end
    end

    // Read valid marks the cycle after the strobe.
    always @* begin
        cfg_rvalid_d = cfg_rd_i;
    end

    always @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            cfg_rvalid_o <= 1'b0;
        end else begin
            cfg_rvalid_o <= cfg_rvalid_d;
        end
    end

    always @* begin
        perr_act_d = perr_set;
    end

    always @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            perr_act_o <= 1'b0;
        end else begin
            perr_act_o <= perr_act_d;
        end
    end

    always @* begin
        err_report_d = sse_set;
    end

    always @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            err_report_o <= 1'b0;
        end else begin
            err_report_o <= err_report_d;
        end
    end

    always @* begin
        int_msg_d = (int_own_i && !intx_off) || int_dn_i;
    end

    always @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            int_msg_o <= 1'b0;
        end else begin
            int_msg_o <= int_msg_d;
        end
    end

    // The copy trails the live command by one cycle.
    always @* begin
        cmd_copy_d = cmd_q;
    end

    always @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            cmd_o <= 16'h0000;
        end else begin
            cmd_o <= cmd_copy_d;
        end
    end
endmodule // spc_top

/* spc_monitor.sv */
// Checker for the identifier and command bank, watching only the top ports.
// Assumes traffic comes after three cycles without any config write.
`timescale 1ns/1ps
module spc_monitor (
    // Clock and reset
    input wire core_clk_i,
    input wire rst_b_i,
    // Watched requests and events
    input wire cfg_wr_i,
    input wire pri_req_i,
    input wire [1:0] pri_kind_i,
    input wire dn_req_i,
    input wire [1:0] dn_kind_i,
    input wire dn_np_i,
    input wire err_msg_i,
    input wire int_dn_i,
    // Watched decisions
    input wire pri_accept_o,
    input wire pri_ignore_o,
    input wire up_fwd_o,
    input wire dn_ur_o,
    input wire dn_ur_cpl_o,
    input wire err_report_o,
    input wire int_msg_o,
    input wire [15:0] cmd_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    // The copy on cmd_o may lag the live command, so checks of its enable bits compare only quiet spells.
    sequence s_calm; !cfg_wr_i [*3]; endsequence
    // Only memory and I/O kinds are gated by bus mastering.
    sequence s_dn; s_calm ##0 dn_req_i && !dn_kind_i[1]; endsequence
    property p_io; s_calm ##0 pri_req_i && pri_kind_i == 2'h1 |=> pri_accept_o == $past(cmd_o[0])
        && pri_ignore_o != $past(cmd_o[0]); endproperty
    a_io: assert property (p_io) else $error("io decision wrong");
    property p_mem; s_calm ##0 pri_req_i && pri_kind_i == 2'h0 |=> pri_accept_o == $past(cmd_o[1])
        && pri_ignore_o != $past(cmd_o[1]); endproperty
    a_mem: assert property (p_mem) else $error("mem decision wrong");
    property p_ur; s_dn ##0 !cmd_o[2] |=> dn_ur_o && !up_fwd_o; endproperty
    a_ur: assert property (p_ur) else $error("no unsupported mark");
    property p_cpl; s_dn ##0 !cmd_o[2] && dn_np_i |=> dn_ur_cpl_o; endproperty
    a_cpl: assert property (p_cpl) else $error("no UR completion");
    property p_fwd; s_dn ##0 cmd_o[2] |=> up_fwd_o && !dn_ur_o; endproperty
    a_fwd: assert property (p_fwd) else $error("no upstream forward");
    property p_rsv; (cmd_o & 16'hFAB8) == 16'h0000; endproperty
    a_rsv: assert property (p_rsv) else $error("fixed command bit set");
    property p_serr; s_calm ##0 err_msg_i |=> err_report_o == $past(cmd_o[8]); endproperty
    a_serr: assert property (p_serr) else $error("error report gate wrong");
    property p_int; int_dn_i |=> int_msg_o; endproperty
    a_int: assert property (p_int) else $error("downstream INTx dropped");
endmodule // spc_monitor
bind spc_top spc_monitor i_spc_monitor (.*);

/* spc_host.sv */
// Host model issuing one-cycle configuration strobes.
// Assumes the read answer lands exactly one cycle after the strobe edge.
`timescale 1ns/1ps
module spc_host (
    input wire core_clk_i,
    output logic cfg_wr_o = 1'b0,
    output logic cfg_rd_o = 1'b0,
    output logic [7:0] cfg_addr_o = 8'h00,
    output logic [31:0] cfg_wdata_o = 32'h00000000,
    input wire [31:0] cfg_rdata_i,
    input wire cfg_rvalid_i
);
    // Idle address and data are inverted so a stale value never passes for a live one.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] din, output logic [31:0] d);
        @(posedge core_clk_i);
        cfg_wr_o <= w;
        cfg_rd_o <= !w;
        cfg_addr_o <= a;
        cfg_wdata_o <= din;
        @(posedge core_clk_i);
        cfg_wr_o <= 1'b0;
        cfg_rd_o <= 1'b0;
        cfg_addr_o <= ~a;
        cfg_wdata_o <= ~din;
        @(posedge core_clk_i);
        d = cfg_rvalid_i ? cfg_rdata_i : 32'hDEADBEEF;
    endtask
endmodule // spc_host

/* test_switch_port_command_config.sv */
// Self-checking bench for the identifier and command bank.
// Assumes the host model owns the config strobes; link events come from here.
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module test_switch_port_command_config;
    localparam logic [15:0] ID = 16'h3C5A; // Arbitrary identifier value.
    logic core_clk_i, rst_b_i, id_load_i, pri_req_i, dn_req_i, dn_np_i, perr_det_i, err_msg_i, int_own_i, int_dn_i;
    logic cfg_wr_i, cfg_rd_i, cfg_rvalid_o, pri_accept_o, pri_ignore_o, up_fwd_o, dn_ur_o, dn_ur_cpl_o;
    logic perr_act_o, err_report_o, int_msg_o, perr_pin_i = 1'b0;
    logic [1:0] pri_kind_i, dn_kind_i = 2'h0;
    logic [3:0] cfg_be_i = 4'hF;
    logic [7:0] cfg_addr_i;
    logic [8:0] ev = 9'h000;
    logic [15:0] cmd_o, id_value_i;
    logic [31:0] cfg_wdata_i, cfg_rdata_o;
    int check_count = 0;
    int fail_count = 0;
    assign {pri_req_i, pri_kind_i, dn_req_i, dn_np_i, perr_det_i, err_msg_i, int_own_i, int_dn_i} = ev;
    spc_top #(.DEVID_RST(ID)) i_spc_top (.*);
    spc_host i_spc_host (.core_clk_i, .cfg_wr_o(cfg_wr_i), .cfg_rd_o(cfg_rd_i), .cfg_addr_o(cfg_addr_i),
        .cfg_wdata_o(cfg_wdata_i), .cfg_rdata_i(cfg_rdata_o), .cfg_rvalid_i(cfg_rvalid_o));
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic fire(input logic [8:0] s, output logic [7:0] o);
        @(posedge core_clk_i);
        ev <= s;
        @(posedge core_clk_i);
        ev <= 9'h000;
        @(posedge core_clk_i);
        o = {pri_accept_o, pri_ignore_o, up_fwd_o, dn_ur_o, dn_ur_cpl_o, perr_act_o, err_report_o, int_msg_o};
    endtask
    task automatic t_id;
        logic [31:0] d;
        i_spc_host.xfer(1'b0, 8'h04, 32'h0, d);
        `CHK(d[15:0], 16'h0000)
        i_spc_host.xfer(1'b1, 8'h00, 32'hFFFFFFFF, d);
        i_spc_host.xfer(1'b0, 8'h00, 32'h0, d);
        `CHK(d[31:16], ID)
        i_spc_host.xfer(1'b0, 8'h40, 32'h0, d);
        `CHK(d, 32'h00000000)
        @(posedge core_clk_i);
        id_load_i <= 1'b1;
        id_value_i <= 16'h1234;
        @(posedge core_clk_i);
        id_load_i <= 1'b0;
        i_spc_host.xfer(1'b0, 8'h00, 32'h0, d);
        `CHK(d[31:16], 16'h1234)
    endtask
    // Each call clears the two status flags while it sets the command.
    task automatic t_cmd(input logic [15:0] c);
        logic [31:0] d;
        logic [7:0] o;
        logic [15:0] e;
        e = c & 16'h0547;
        i_spc_host.xfer(1'b1, 8'h04, {16'h4100, c}, d);
        i_spc_host.xfer(1'b0, 8'h04, 32'h0, d);
        `CHK(d[15:0], e)
        fire(9'h100, o);
        `CHK(o, {e[1], !e[1], 6'h00})
        fire(9'h140, o);
        `CHK(o, {e[0], !e[0], 6'h00})
        fire(9'h030, o);
        `CHK(o, {2'h0, e[2], !e[2], !e[2], 3'h0})
        fire(9'h00E, o);
        `CHK(o[1:0], {e[8], !e[10]})
        if (e[6]) `CHK(o[2], 1'b1)
        fire(9'h001, o);
        `CHK(o[0], 1'b1)
        i_spc_host.xfer(1'b0, 8'h04, 32'h0, d);
        `CHK(d[30], e[8])
        if (!e[6]) `CHK(d[24], 1'b0)
        i_spc_host.xfer(1'b1, 8'h04, {16'h0100, c}, d);
        perr_pin_i <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        perr_pin_i <= 1'b0;
        i_spc_host.xfer(1'b0, 8'h04, 32'h0, d);
        `CHK(d[24], e[6])
    endtask
    initial begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end
    initial begin
        repeat (3000) @(posedge core_clk_i);
        fail_count++;
        tally_and_finish;
    end
    initial begin
        rst_b_i = 1'b0;
        id_load_i = 1'b0;
        id_value_i = 16'h0000;
        repeat (5) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        t_id;
        t_cmd(16'h0000);
        t_cmd(16'hFFFF);
        t_cmd(16'h0001);
        t_cmd(16'h0002);
        tally_and_finish;
    end
endmodule // test_switch_port_command_config
